// >>> verification/tmrwv_pin_model.sv
// Pin-side model: external clock inputs and io line levels.
// Assumes the bench moves drive levels right after clock edges.
`timescale 1ns/1ps
`default_nettype none
module tmrwv_pin_model (
  input  wire logic [2:0] ext_drv,
  input  wire logic [2:0] b_drv,
  input  wire logic [2:0] io_line_a_out,
  input  wire logic [2:0] io_line_a_oe,
  input  wire logic [2:0] io_line_b_out,
  input  wire logic [2:0] io_line_b_oe,
  output logic      [2:0] ext_clk_in,
  output logic      [2:0] io_line_a_in,
  output logic      [2:0] io_line_b_in
);
  assign ext_clk_in = ext_drv;
  // Line A has a pull-down when nobody drives it
  assign io_line_a_in = io_line_a_oe & io_line_a_out;
  assign io_line_b_in = (io_line_b_oe & io_line_b_out) | (~io_line_b_oe & b_drv);
endmodule // tmrwv_pin_model
`default_nettype wire

// >>> verification/tmrwv_top_assertions.sv
// Port checks for the timer top.
// Bound to tmrwv_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tmrwv_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [2:0] io_line_a_oe,
  input wire logic [2:0] io_line_b_oe,
  input wire logic [2:0] io_line_b_out,
  input wire logic [2:0] chan_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  a_ar_answer:
    assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  a_aw_pulse:
    assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
  a_bresp_code:
    assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}) else $error("bad bresp");
  a_b_needs_a:
    assert property ((io_line_b_oe & ~io_line_a_oe) == 3'h0) else $error("line b without a");
  a_line_b_quiet:
    assert property (((io_line_b_out ^ $past(io_line_b_out)) & ~io_line_b_oe
      & ~$past(io_line_b_oe)) == 3'h0) else $error("undriven line b moved");
  a_reset_quiet:
    assert property ($rose(aresetn) |-> io_line_a_oe == 3'h0 && chan_irq == 3'h0)
      else $error("outputs busy after reset");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_line_b_in: cover property (io_line_a_oe[2] && !io_line_b_oe[2]);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule // tmrwv_chk
bind tmrwv_top tmrwv_chk chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .io_line_a_oe, .io_line_b_oe,
  .io_line_b_out, .chan_irq);
`default_nettype wire

// >>> verification/tmrwv_top_tb.sv
// Self-checking bench for the three-channel waveform timer.
// Assumes tmrwv_top, tmrwv_pin_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tmrwv_top_tb;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic w; logic [31:0] e; logic [1:0] r;}
    tmrwv_row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, v0;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [2:0]  ext_drv, b_drv, ext_clk_in, io_line_a_in, io_line_b_in, io_line_a_out;
  logic [2:0]  io_line_a_oe, io_line_b_out, io_line_b_oe, chan_irq;
  integer      n_errors = 0, n_checks = 0, cyc = 0, i;
  tmrwv_row_t  rows [8];
  tmrwv_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_clk_in, .io_line_a_in, .io_line_b_in, .io_line_a_out,
    .io_line_a_oe, .io_line_b_out, .io_line_b_oe, .chan_irq);
  tmrwv_pin_model pin_u (.ext_drv, .b_drv, .io_line_a_out, .io_line_a_oe, .io_line_b_out,
    .io_line_b_oe, .ext_clk_in, .io_line_a_in, .io_line_b_in);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      summarize;
    end
  end
  task summarize;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ready and response are taken at the edge they are sampled; ends off-edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rv, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(negedge aclk);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_drv, b_drv} = '0;
    s_axi_wstrb = 4'hf;
    rows = '{{8'h04, 32'h0, 1'b0, 32'h0, 2'h0},
             {8'h10, 32'h0, 1'b0, 32'h0, 2'h0},
             {8'h1c, 32'h1234, 1'b1, 32'h1234, 2'h0},
             {8'h14, 32'h55, 1'b1, 32'h0, 2'h0},
             {8'hc4, 32'h39, 1'b1, 32'h39, 2'h0},
             {8'h9c, 32'h77, 1'b1, 32'h77, 2'h0},
             {8'h08, 32'h0, 1'b1, 32'h0, 2'h2},
             {8'hc8, 32'h0, 1'b0, 32'h0, 2'h2}};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        chk("bresp", {30'h0, rows[i].r}, {30'h0, rs});
      end
      rd(rows[i].a);
      chk("resp", {30'h0, rows[i].r}, {30'h0, rs});
      if (rows[i].r == 2'h0) chk("data", rows[i].e, rv);
    end
    wr(8'h1c, 32'h5);
    wr(8'h04, 32'hc000);
    wr(8'h00, 32'h5);
    repeat (3) begin
      rd(8'h10);
      chk("cv within limit", 32'h1, {31'h0, rv <= 32'h5});
    end
    rd(8'h20);
    chk("limit flag", 32'h1, {31'h0, rv[4]});
    wr(8'h04, 32'h8000);
    repeat (80) @(posedge aclk);
    rd(8'h10);
    chk("cv past limit", 32'h1, {31'h0, rv > 32'h28});
    wr(8'h00, 32'h4);
    rd(8'h10);
    chk("cv after trigger", 32'h1, {31'h0, rv < 32'h10});
    wr(8'h1c, 32'h8);
    wr(8'h04, 32'hc040);
    wr(8'h00, 32'h5);
    repeat (40) @(posedge aclk);
    rd(8'h10);
    v0 = rv;
    rd(8'h10);
    chk("cv stopped", v0, rv);
    chk("cv stop value", 32'h0, v0);
    wr(8'h04, 32'hc080);
    wr(8'h00, 32'h4);
    repeat (40) @(posedge aclk);
    rd(8'h20);
    chk("clock disabled", 32'h0, {31'h0, rv[16]});
    wr(8'h44, 32'h408000);
    wr(8'h54, 32'h99);
    rd(8'h54);
    chk("compare a wave", 32'h99, rv);
    wr(8'hc0, 32'h0);
    repeat (4) @(posedge aclk);
    chk("no sync", 32'h0, {31'h0, io_line_a_out[1]});
    wr(8'hc0, 32'h1);
    repeat (4) @(posedge aclk);
    chk("sync set a", 32'h1, {31'h0, io_line_a_out[1] & io_line_a_oe[1]});
    wr(8'h84, 32'h309100);
    chk("line b input", 32'h0, {31'h0, io_line_b_oe[2]});
    @(posedge aclk) b_drv <= 3'h4;
    repeat (4) @(posedge aclk);
    chk("event toggles a", 32'h1, {31'h0, io_line_a_out[2]});
    wr(8'hc4, 32'h0);
    wr(8'h04, 32'h108500);
    chk("line b kept", 32'h1, {31'h0, io_line_b_oe[0]});
    @(posedge aclk) ext_drv <= 3'h1;
    repeat (4) @(posedge aclk);
    chk("routed event", 32'h1, {31'h0, io_line_a_out[0]});
    wr(8'h5c, 32'hff);
    wr(8'h44, 32'he000);
    wr(8'h40, 32'h5);
    repeat (20) @(posedge aclk);
    wr(8'h40, 32'h4);
    rd(8'h50);
    v0 = rv;
    rd(8'h50);
    chk("cv counts down", 32'h1, {31'h0, rv < v0});
    wr(8'h44, 32'h100);
    @(posedge aclk) b_drv <= 3'h6;
    repeat (4) @(posedge aclk);
    rd(8'h60);
    chk("capture trigger flag", 32'h1, {31'h0, rv[7]});
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("reset line a oe", 32'h0, {29'h0, io_line_a_oe});
    rd(8'h44);
    chk("mode after reset", 32'h0, rv);
    summarize;
  end
endmodule // tmrwv_top_tb
`default_nettype wire

// >>> verilog/tmrwv_channel.v
// One timer channel: counter, compare, triggers, output controller.
// Assumes inputs synchronous to aclk; counts once per aclk while running.
`timescale 1ns/1ps
`default_nettype none
`include "tmrwv_regs.vh"

module tmrwv_channel #(
  parameter CW = 16
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [31:0]   mode,
  input  wire [CW-1:0] cmp_a,
  input  wire [CW-1:0] cmp_b,
  input  wire [CW-1:0] cmp_c,
  input  wire          clk_en_cmd,
  input  wire          clk_dis_cmd,
  input  wire          sw_trig,
  input  wire [2:0]    ext_line,
  input  wire          io_a_in,
  input  wire          io_b_in,
  output wire [CW-1:0] count,
  output wire          io_a_out,
  output wire          io_a_oe,
  output wire          io_b_out,
  output wire          io_b_oe,
  output wire [4:0]    events,
  output wire          clk_on
);

  function det_edge;
    input [1:0] sel;
    input       cur;
    input       prev;
    begin
      case (sel)
        `TMRWV_EDGE_RISE: det_edge = cur & ~prev;
        `TMRWV_EDGE_FALL: det_edge = ~cur & prev;
        `TMRWV_EDGE_BOTH: det_edge = cur ^ prev;
        default:          det_edge = 1'b0;
      endcase
    end
  endfunction

  function act_apply;
    input [1:0] act;
    input       cur;
    begin
      case (act)
        `TMRWV_ACT_SET: act_apply = 1'b1;
        `TMRWV_ACT_CLR: act_apply = 1'b0;
        `TMRWV_ACT_TOG: act_apply = ~cur;
        default:        act_apply = cur;
      endcase
    end
  endfunction

  localparam [CW-1:0] MAXV = {CW{1'b1}};

  wire       wave   = mode[`TMRWV_CMR_WAVE];
  wire [1:0] wsel   = mode[`TMRWV_CMR_PROFILE_SELECT_LO+1:`TMRWV_CMR_PROFILE_SELECT_LO];
  wire [1:0] event_source_field   = mode[`TMRWV_CMR_EVENT_SOURCE_FIELD_LO+1:`TMRWV_CMR_EVENT_SOURCE_FIELD_LO];
  wire [1:0] eedg   = mode[`TMRWV_CMR_EVENT_EDGE_FIELD_LO+1:`TMRWV_CMR_EVENT_EDGE_FIELD_LO];
  wire       b_in   = wave & (event_source_field == `TMRWV_EVENT_SOURCE_FIELD_IOB);

  reg [CW-1:0] cnt_ff;
  reg          down_ff;
  reg          en_ff;
  reg          run_ff;
  reg          sig_prev_ff;
  reg          a_ff;
  reg          b_ff;
  reg          sig;

  always @* begin
    if (!wave)
      sig = mode[`TMRWV_CMR_CAPTURE_TRIGGER_LINE_SELECT] ? io_a_in : io_b_in;
    else
      case (event_source_field)
        2'h0:    sig = io_b_in;
        2'h1:    sig = ext_line[0];
        2'h2:    sig = ext_line[1];
        default: sig = ext_line[2];
      endcase
  end

  // Capture view and waveform view share the edge field position
  wire ext_evt  = det_edge(eedg, sig, sig_prev_ff);
  wire ext_trig = ext_evt & (~wave | mode[`TMRWV_CMR_EVENT_TRIGGER_ENABLE]);
  wire rc_hit   = run_ff & (cnt_ff == cmp_c);
  wire ra_hit   = run_ff & (cnt_ff == cmp_a);
  wire rb_hit   = run_ff & (cnt_ff == cmp_b) & ~b_in;
  // RC trigger only where the profile allows it; capture honours COMPARE_TRIGGER_ENABLE
  wire rc_trig  = rc_hit & (wave ? wsel[1] & ~wsel[0]
                                 : mode[`TMRWV_CMR_COMPARE_TRIGGER_ENABLE]);
  wire trig     = sw_trig | ext_trig | rc_trig;
  wire stop     = wave & rc_hit & mode[`TMRWV_CMR_COMPARE_STOP_BIT];
  wire dis      = clk_dis_cmd | (wave & rc_hit & mode[`TMRWV_CMR_COMPARE_DISABLE_BIT]);
  wire top_hit  = wsel[1] ? (cnt_ff == cmp_c) : (cnt_ff == MAXV);

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff      <= {CW{1'b0}};
      down_ff     <= 1'b0;
      en_ff       <= 1'b0;
      run_ff      <= 1'b0;
      sig_prev_ff <= 1'b0;
      a_ff        <= 1'b0;
      b_ff        <= 1'b0;
    end else begin
      sig_prev_ff <= sig;
      en_ff       <= ~dis & (en_ff | clk_en_cmd);
      if (dis)
        run_ff <= 1'b0;
      else if ((en_ff | clk_en_cmd) && (sw_trig | ext_trig))
        run_ff <= 1'b1;
      else if (stop)
        run_ff <= 1'b0; // Stop outranks the period trigger
      else if ((en_ff | clk_en_cmd) && rc_trig)
        run_ff <= 1'b1;
      if (wave && wsel[0] && run_ff && (sw_trig | ext_trig)) begin
        down_ff <= ~down_ff;
      end else if (wave && wsel[0] && run_ff && !stop && !dis) begin
        if (!down_ff && top_hit)
          down_ff <= 1'b1;
        else if (down_ff && cnt_ff == {{(CW-1){1'b0}}, 1'b1})
          down_ff <= 1'b0;
        if (down_ff)
          cnt_ff <= cnt_ff - 1'b1;
        else if (!top_hit)
          cnt_ff <= cnt_ff + 1'b1;
        else
          cnt_ff <= cnt_ff - 1'b1;
      end else if (trig && (en_ff | clk_en_cmd)) begin
        // Idle up-down channel also starts from zero, counting up
        cnt_ff  <= {CW{1'b0}};
        down_ff <= 1'b0;
      end else if (run_ff && !stop && !dis) begin
        cnt_ff <= cnt_ff + 1'b1; // wraps past max
      end
      if (wave) begin
        if (ra_hit)
          a_ff <= act_apply(mode[`TMRWV_CMR_ACPA_LO+1:`TMRWV_CMR_ACPA_LO], a_ff);
        if (rc_hit)
          a_ff <= act_apply(mode[`TMRWV_CMR_ACPC_LO+1:`TMRWV_CMR_ACPC_LO], a_ff);
        if (ext_evt)
          a_ff <= act_apply(mode[`TMRWV_CMR_AEEVT_LO+1:`TMRWV_CMR_AEEVT_LO], a_ff);
        if (sw_trig)
          a_ff <= act_apply(mode[`TMRWV_CMR_ASWTRG_LO+1:`TMRWV_CMR_ASWTRG_LO], a_ff);
        if (!b_in) begin
          if (rb_hit)
            b_ff <= act_apply(mode[`TMRWV_CMR_BCPB_LO+1:`TMRWV_CMR_BCPB_LO], b_ff);
          if (rc_hit)
            b_ff <= act_apply(mode[`TMRWV_CMR_BCPC_LO+1:`TMRWV_CMR_BCPC_LO], b_ff);
          if (ext_evt)
            b_ff <= act_apply(mode[`TMRWV_CMR_BEEVT_LO+1:`TMRWV_CMR_BEEVT_LO], b_ff);
          if (sw_trig)
            b_ff <= act_apply(mode[`TMRWV_CMR_BSWTRG_LO+1:`TMRWV_CMR_BSWTRG_LO], b_ff);
        end
      end
    end
  end

  assign count    = cnt_ff;
  assign io_a_out = a_ff;
  assign io_a_oe  = wave;
  assign io_b_out = b_ff;
  assign io_b_oe  = wave & ~b_in;
  assign clk_on   = en_ff;
  // Events: overflow, A, B, C match, external trigger
  assign events   = {ext_trig, rc_hit, rb_hit, ra_hit,
                     run_ff & ~down_ff & (cnt_ff == MAXV)};

endmodule // tmrwv_channel
`default_nettype wire

// >>> verilog/tmrwv_regs.vh
// Register map, field positions and codes of the three-channel waveform timer.
// Included by every design file of the block; holds definitions only.
`ifndef TMRWV_REGS_VH
`define TMRWV_REGS_VH

`define TMRWV_CH_STRIDE      8'h40
`define TMRWV_OFF_CCR        6'h00
`define TMRWV_OFF_CMR        6'h04
`define TMRWV_OFF_CV         6'h10
`define TMRWV_OFF_RA         6'h14
`define TMRWV_OFF_RB         6'h18
`define TMRWV_OFF_RC         6'h1c
`define TMRWV_OFF_SR         6'h20
`define TMRWV_OFF_IER        6'h24
`define TMRWV_OFF_IDR        6'h28
`define TMRWV_OFF_IMR        6'h2c
`define TMRWV_ADDR_BCR       8'hc0
`define TMRWV_ADDR_BMR       8'hc4

// Channel command bits
`define TMRWV_CCR_CLKEN      0
`define TMRWV_CCR_CLKDIS     1
`define TMRWV_CCR_SOFTWARE_TRIGGER_COMMAND      2
// Block command bit
`define TMRWV_BCR_SYNC       0

// Channel mode fields, capture view
`define TMRWV_CMR_CAPTURE_TRIGGER_EDGE_LO 8
`define TMRWV_CMR_CAPTURE_TRIGGER_LINE_SELECT     10
`define TMRWV_CMR_COMPARE_TRIGGER_ENABLE     14
// Channel mode fields, waveform view
`define TMRWV_CMR_EVENT_EDGE_FIELD_LO 8
`define TMRWV_CMR_EVENT_SOURCE_FIELD_LO    10
`define TMRWV_CMR_EVENT_TRIGGER_ENABLE     12
`define TMRWV_CMR_PROFILE_SELECT_LO  13
`define TMRWV_CMR_WAVE       15
`define TMRWV_CMR_COMPARE_STOP_BIT    6
`define TMRWV_CMR_COMPARE_DISABLE_BIT     7
`define TMRWV_CMR_ACPA_LO    16
`define TMRWV_CMR_ACPC_LO    18
`define TMRWV_CMR_AEEVT_LO   20
`define TMRWV_CMR_ASWTRG_LO  22
`define TMRWV_CMR_BCPB_LO    24
`define TMRWV_CMR_BCPC_LO    26
`define TMRWV_CMR_BEEVT_LO   28
`define TMRWV_CMR_BSWTRG_LO  30
`define TMRWV_CMR_RESET      32'h0000_0000

// Flag bits
`define TMRWV_SR_COVFS       0
`define TMRWV_SR_CPAS        2
`define TMRWV_SR_CPBS        3
`define TMRWV_SR_CPCS        4
`define TMRWV_SR_ETRGS       7
`define TMRWV_SR_CLKSTA      16
`define TMRWV_SR_MASK        8'h9d

// Profile codes
`define TMRWV_WS_UP_MAX      2'h0
`define TMRWV_WS_UPDN_MAX    2'h1
`define TMRWV_WS_UP_RC       2'h2
`define TMRWV_WS_UPDN_RC     2'h3

// Edge codes
`define TMRWV_EDGE_NONE      2'h0
`define TMRWV_EDGE_RISE      2'h1
`define TMRWV_EDGE_FALL      2'h2
`define TMRWV_EDGE_BOTH      2'h3

// Output actions
`define TMRWV_ACT_NONE       2'h0
`define TMRWV_ACT_SET        2'h1
`define TMRWV_ACT_CLR        2'h2
`define TMRWV_ACT_TOG        2'h3

// Event source codes
`define TMRWV_EVENT_SOURCE_FIELD_IOB       2'h0

// Clock routing field width
`define TMRWV_ROUTE_W        2

`endif

// >>> verilog/tmrwv_routing.v
// External clock line routing of the timer block.
// Assumes all inputs synchronous to aclk; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "tmrwv_regs.vh"

module tmrwv_routing (
  input  wire [5:0] routing,
  input  wire [2:0] ext_clk_in,
  input  wire [2:0] io_a,
  output reg  [2:0] ext_line
);

  always @* begin
    case (routing[1:0])
      2'h0:    ext_line[0] = ext_clk_in[0];
      2'h2:    ext_line[0] = io_a[1];
      2'h3:    ext_line[0] = io_a[2];
      default: ext_line[0] = 1'b0;
    endcase
    case (routing[3:2])
      2'h0:    ext_line[1] = ext_clk_in[1];
      2'h2:    ext_line[1] = io_a[0];
      2'h3:    ext_line[1] = io_a[2];
      default: ext_line[1] = 1'b0;
    endcase
    case (routing[5:4])
      2'h0:    ext_line[2] = ext_clk_in[2];
      2'h2:    ext_line[2] = io_a[0];
      2'h3:    ext_line[2] = io_a[1];
      default: ext_line[2] = 1'b0;
    endcase
  end

endmodule // tmrwv_routing
`default_nettype wire

// >>> verilog/tmrwv_top.v
// Three-channel 16-bit waveform timer with AXI4-Lite register slave.
// Assumes pins synchronous to aclk and a single AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "tmrwv_regs.vh"

module tmrwv_top #(
  parameter CW = 16
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [2:0]  ext_clk_in,
  input  wire [2:0]  io_line_a_in,
  input  wire [2:0]  io_line_b_in,
  output reg  [2:0]  io_line_a_out,
  output reg  [2:0]  io_line_a_oe,
  output reg  [2:0]  io_line_b_out,
  output reg  [2:0]  io_line_b_oe,
  output reg  [2:0]  chan_irq
);

  localparam [1:0] RESP_OK  = 2'h0;
  localparam [1:0] RESP_ERR = 2'h2;

  reg [7:0]  aw_ff;
  reg        aw_ok_ff;
  reg [31:0] wd_ff;
  reg [3:0]  ws_ff;
  reg        wd_ok_ff;
  reg [5:0]  route_ff;
  reg [95:0] mode_ff;
  reg [47:0] ra_ff;
  reg [47:0] rb_ff;
  reg [47:0] rc_ff;
  reg [23:0] sr_ff;
  reg [23:0] imr_ff;
  reg [2:0]  sw_ff;
  reg [2:0]  en_cmd_ff;
  reg [2:0]  dis_cmd_ff;

  wire [47:0] cnt;
  wire [2:0]  a_out;
  wire [2:0]  a_oe;
  wire [2:0]  b_out;
  wire [2:0]  b_oe;
  wire [14:0] evts;
  wire [2:0]  clk_on;
  wire [2:0]  ext_line;

  // Write performed once both halves are held and no response is pending
  wire       wr_go  = aw_ok_ff & wd_ok_ff & ~s_axi_bvalid;
  wire [1:0] wr_ch  = aw_ff[7:6];
  wire [5:0] wr_off = aw_ff[5:0];
  wire       wr_blk = (wr_ch == 2'h3);

  function [7:0] wmask8;
    input [31:0] d;
    input [3:0]  s;
    begin
      wmask8 = d[7:0] & {8{s[0]}};
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      if (a[7:6] == 2'h3)
        mapped = (a == `TMRWV_ADDR_BCR) || (a == `TMRWV_ADDR_BMR);
      else
        mapped = (a[5:0] == `TMRWV_OFF_CCR) || (a[5:0] == `TMRWV_OFF_CMR) ||
                 ((a[5:0] >= `TMRWV_OFF_CV) && (a[5:0] <= `TMRWV_OFF_IMR) &&
                  (a[1:0] == 2'h0));
    end
  endfunction

  tmrwv_routing u_route (
    .routing    (route_ff),
    .ext_clk_in (ext_clk_in),
    .io_a       (io_line_a_out),
    .ext_line   (ext_line)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      tmrwv_channel #(.CW(CW)) u_ch (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .mode        (mode_ff[32*g +: 32]),
        .cmp_a       (ra_ff[16*g +: 16]),
        .cmp_b       (rb_ff[16*g +: 16]),
        .cmp_c       (rc_ff[16*g +: 16]),
        .clk_en_cmd  (en_cmd_ff[g]),
        .clk_dis_cmd (dis_cmd_ff[g]),
        .sw_trig     (sw_ff[g]),
        .ext_line    (ext_line),
        .io_a_in     (io_line_a_in[g]),
        .io_b_in     (io_line_b_in[g]),
        .count       (cnt[16*g +: 16]),
        .io_a_out    (a_out[g]),
        .io_a_oe     (a_oe[g]),
        .io_b_out    (b_out[g]),
        .io_b_oe     (b_oe[g]),
        .events      (evts[5*g +: 5]),
        .clk_on      (clk_on[g])
      );
    end
  endgenerate

  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      aw_ff         <= 8'h00;
      aw_ok_ff      <= 1'b0;
      wd_ff         <= 32'h0000_0000;
      ws_ff         <= 4'h0;
      wd_ok_ff      <= 1'b0;
      route_ff      <= 6'h00;
      mode_ff       <= {3{`TMRWV_CMR_RESET}};
      ra_ff         <= 48'h0;
      rb_ff         <= 48'h0;
      rc_ff         <= 48'h0;
      sr_ff         <= 24'h0;
      imr_ff        <= 24'h0;
      sw_ff         <= 3'h0;
      en_cmd_ff     <= 3'h0;
      dis_cmd_ff    <= 3'h0;
      chan_irq      <= 3'h0;
      io_line_a_out <= 3'h0;
      io_line_a_oe  <= 3'h0;
      io_line_b_out <= 3'h0;
      io_line_b_oe  <= 3'h0;
    end else begin
      io_line_a_out <= a_out;
      io_line_a_oe  <= a_oe;
      io_line_b_out <= b_out;
      io_line_b_oe  <= b_oe;
      s_axi_awready <= ~aw_ok_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wd_ok_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff    <= s_axi_awaddr;
        aw_ok_ff <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_ff    <= s_axi_wdata;
        ws_ff    <= s_axi_wstrb;
        wd_ok_ff <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      sw_ff      <= 3'h0;
      en_cmd_ff  <= 3'h0;
      dis_cmd_ff <= 3'h0;
      if (wr_go) begin
        aw_ok_ff     <= 1'b0;
        wd_ok_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_ff) ? RESP_OK : RESP_ERR;
        if (wr_blk) begin
          if (aw_ff == `TMRWV_ADDR_BCR && ws_ff[0] && wd_ff[`TMRWV_BCR_SYNC])
            sw_ff <= 3'h7;
          if (aw_ff == `TMRWV_ADDR_BMR && ws_ff[0])
            route_ff <= wd_ff[5:0];
        end else begin
          case (wr_off)
            `TMRWV_OFF_CCR: if (ws_ff[0]) begin
              sw_ff[wr_ch]      <= wd_ff[`TMRWV_CCR_SOFTWARE_TRIGGER_COMMAND];
              en_cmd_ff[wr_ch]  <= wd_ff[`TMRWV_CCR_CLKEN];
              dis_cmd_ff[wr_ch] <= wd_ff[`TMRWV_CCR_CLKDIS];
            end
            `TMRWV_OFF_CMR: for (i = 0; i < 4; i = i + 1)
              if (ws_ff[i])
                mode_ff[32*wr_ch + 8*i +: 8] <= wd_ff[8*i +: 8];
            `TMRWV_OFF_RA: if (mode_ff[32*wr_ch + `TMRWV_CMR_WAVE]) begin
              if (ws_ff[0]) ra_ff[16*wr_ch +: 8]     <= wd_ff[7:0];
              if (ws_ff[1]) ra_ff[16*wr_ch + 8 +: 8] <= wd_ff[15:8];
            end
            `TMRWV_OFF_RB: if (mode_ff[32*wr_ch + `TMRWV_CMR_WAVE]) begin
              if (ws_ff[0]) rb_ff[16*wr_ch +: 8]     <= wd_ff[7:0];
              if (ws_ff[1]) rb_ff[16*wr_ch + 8 +: 8] <= wd_ff[15:8];
            end
            `TMRWV_OFF_RC: begin
              if (ws_ff[0]) rc_ff[16*wr_ch +: 8]     <= wd_ff[7:0];
              if (ws_ff[1]) rc_ff[16*wr_ch + 8 +: 8] <= wd_ff[15:8];
            end
            `TMRWV_OFF_IER:
              imr_ff[8*wr_ch +: 8] <= imr_ff[8*wr_ch +: 8] |
                                      (wmask8(wd_ff, ws_ff) & `TMRWV_SR_MASK);
            `TMRWV_OFF_IDR:
              imr_ff[8*wr_ch +: 8] <= imr_ff[8*wr_ch +: 8] & ~wmask8(wd_ff, ws_ff);
            default: ;
          endcase
        end
      end
      // Flags clear on read; a same-cycle event still sets them
      for (i = 0; i < 3; i = i + 1) begin
        if (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:6] == i[1:0] &&
            s_axi_araddr[5:0] == `TMRWV_OFF_SR)
          sr_ff[8*i +: 8] <= 8'h00;
        if (evts[5*i + 0]) sr_ff[8*i + `TMRWV_SR_COVFS] <= 1'b1;
        if (evts[5*i + 1]) sr_ff[8*i + `TMRWV_SR_CPAS]  <= 1'b1;
        if (evts[5*i + 2]) sr_ff[8*i + `TMRWV_SR_CPBS]  <= 1'b1;
        if (evts[5*i + 3]) sr_ff[8*i + `TMRWV_SR_CPCS]  <= 1'b1;
        if (evts[5*i + 4]) sr_ff[8*i + `TMRWV_SR_ETRGS] <= 1'b1;
        chan_irq[i] <= |(sr_ff[8*i +: 8] & imr_ff[8*i +: 8]);
      end
    end
  end

  // Read channel: address taken, data answered the next cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr == `TMRWV_ADDR_BMR)
          s_axi_rdata <= {26'h0, route_ff};
        else if (s_axi_araddr[7:6] != 2'h3)
          case (s_axi_araddr[5:0])
            `TMRWV_OFF_CMR: s_axi_rdata <= mode_ff[32*s_axi_araddr[7:6] +: 32];
            `TMRWV_OFF_CV:  s_axi_rdata <= {16'h0, cnt[16*s_axi_araddr[7:6] +: 16]};
            `TMRWV_OFF_RA:  s_axi_rdata <= {16'h0, ra_ff[16*s_axi_araddr[7:6] +: 16]};
            `TMRWV_OFF_RB:  s_axi_rdata <= {16'h0, rb_ff[16*s_axi_araddr[7:6] +: 16]};
            `TMRWV_OFF_RC:  s_axi_rdata <= {16'h0, rc_ff[16*s_axi_araddr[7:6] +: 16]};
            `TMRWV_OFF_SR:  s_axi_rdata <= {15'h0, clk_on[s_axi_araddr[7:6]],
                                            8'h0, sr_ff[8*s_axi_araddr[7:6] +: 8]};
            `TMRWV_OFF_IMR: s_axi_rdata <= {24'h0, imr_ff[8*s_axi_araddr[7:6] +: 8]};
            default:        s_axi_rdata <= 32'h0000_0000;
          endcase
      end
    end
  end

endmodule // tmrwv_top
`default_nettype wire
